// *** tlvirq_cfg.svh ***
`ifndef TLVIRQ_CFG_SVH
`define TLVIRQ_CFG_SVH
// source count and query-order indices
`define TLVIRQ_NSRC 12
`define TLVIRQ_NFLAG 13
`define TLVIRQ_SRC_EXT0 4'h0
`define TLVIRQ_SRC_T0 4'h1
`define TLVIRQ_SRC_EXT1 4'h2
`define TLVIRQ_SRC_T1 4'h3
`define TLVIRQ_SRC_UART 4'h4
`define TLVIRQ_SRC_T2 4'h5
`define TLVIRQ_SRC_ADC 4'h6
`define TLVIRQ_SRC_SSI 4'h7
`define TLVIRQ_SRC_PWM 4'h8
`define TLVIRQ_SRC_BTM 4'h9
`define TLVIRQ_SRC_EXT2 4'ha
`define TLVIRQ_SRC_CMP 4'hb
// flag bit of the serial transmit-done flag
`define TLVIRQ_FLAG_TX 12
// vector layout
`define TLVIRQ_VEC_BASE 16'h0003
`define TLVIRQ_VEC_STEP 16'h0008
`define TLVIRQ_VEC_CMP 16'h0063
// flags cleared by hardware on acceptance
`define TLVIRQ_HW_AUTO 12'h040f
// sources able to wake from stop
`define TLVIRQ_WAKE_MASK 12'h0e05
// reset values
`define TLVIRQ_FLAG_RST 13'h0000
`define TLVIRQ_VEC_RST 16'h0000
`endif

// *** tlvirq_pkg.sv ***
package tlvirq_pkg;
  // index of a source in query order
  typedef logic [3:0] tlvirq_src_t;
  // trigger selection of one external pin
  typedef enum logic [1:0] {
    TLVIRQ_EDGE_NONE = 2'b00,
    TLVIRQ_EDGE_RISE = 2'b01,
    TLVIRQ_EDGE_FALL = 2'b10,
    TLVIRQ_EDGE_BOTH = 2'b11
  } tlvirq_edge_t;
endpackage : tlvirq_pkg

// *** tlvirq_edge_if.sv ***
`timescale 1ns/1ps
`default_nettype none
// carries the external pins, their trigger modes and detected events
interface tlvirq_edge_if;
  logic [2:0] pin; // pin levels
  tlvirq_pkg::tlvirq_edge_t mode [3]; // per-pin trigger mode
  logic [2:0] hit; // one-cycle event per pin
  modport detect (input pin, input mode, output hit);
  modport user (output pin, output mode, input hit);
endinterface : tlvirq_edge_if
`default_nettype wire

// *** tlvirq_edge.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "tlvirq_cfg.svh"
// edge detector for the three external request pins
module tlvirq_edge (
  input wire logic clk_i,
  input wire logic rst_n_i,
  tlvirq_edge_if.detect eif
);
  logic [2:0] prev_r; // last sampled pin levels
  logic primed_r; // first sample taken
  logic [2:0] hit_r; // registered events
  logic [2:0] hit_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // per-pin edge decode
  always_comb
  begin
    for (int i = 0; i < 3; i++)
    begin
      case (eif.mode[i])
        tlvirq_pkg::TLVIRQ_EDGE_RISE: hit_nxt[i] = eif.pin[i] & ~prev_r[i];
        tlvirq_pkg::TLVIRQ_EDGE_FALL: hit_nxt[i] = ~eif.pin[i] & prev_r[i];
        tlvirq_pkg::TLVIRQ_EDGE_BOTH: hit_nxt[i] = eif.pin[i] ^ prev_r[i];
        default: hit_nxt[i] = 1'b0;
      endcase
    end
    if (!primed_r)
    begin
      hit_nxt = 3'h0; // no edge before first sample
    end
  end

  // sample pins and register events
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      prev_r <= 3'h0;
      primed_r <= 1'b0;
      hit_r <= 3'h0;
    end
    else
    begin
      prev_r <= eif.pin;
      primed_r <= 1'b1;
      hit_r <= hit_nxt;
    end
  end

  assign eif.hit = hit_r;
endmodule : tlvirq_edge
`default_nettype wire

// *** tlvirq_top.sv ***
// Functional notes
// - twelve sources, each high or low priority
// - external pins trigger rising, falling or both
// - forward only with global and source enable
// - fixed vectors, lower vector wins within level
// - timer 0/1 flags cleared on acceptance
// - timer 2 flag cleared only by software
// - serial rx/tx flags held until software clears
// - conversion start clears, conversion end sets
// - sync serial flag set, software clears
// - pwm flag sets regardless, enable gates request
// - external 0/1/2 flags cleared by hardware
// - only ext, base timer, comparator wake stop
// - high preempts low, equal never preempts
// - same-level request held pending until return
// - core pushes counter, loads vector, return restores; core model only loads vector
`timescale 1ns/1ps
`default_nettype none
`include "tlvirq_cfg.svh"
module tlvirq_top #(
  parameter int NSRC = `TLVIRQ_NSRC
) (
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire logic global_irq_enable_i,
  input wire logic [NSRC-1:0] irq_enable_i,
  input wire logic [NSRC-1:0] irq_prio_high_i,
  input wire logic ext_request_0_i,
  input wire logic ext_request_1_i,
  input wire logic ext_request_2_i,
  input wire logic [5:0] ext_mode_i,
  input wire logic timer0_overflow_i,
  input wire logic timer1_overflow_i,
  input wire logic timer2_overflow_i,
  input wire logic serial_rx_done_i,
  input wire logic serial_tx_done_i,
  input wire logic conversion_start_i,
  input wire logic conversion_end_i,
  input wire logic sync_serial_done_i,
  input wire logic pwm_period_pass_i,
  input wire logic base_timer_tick_i,
  input wire logic comparator_event_i,
  input wire logic [`TLVIRQ_NFLAG-1:0] flag_clear_i,
  input wire logic stop_mode_i,
  input wire logic irq_accept_i,
  input wire logic irq_return_i,
  output logic irq_req_o,
  output logic [15:0] irq_vector_o,
  output logic [`TLVIRQ_NFLAG-1:0] flags_o,
  output logic [1:0] in_service_o,
  output logic wake_o
);
  ////////////////////////////////////////////////////////////////////////////
  // reset release
  logic rst_meta_r; // first synchroniser stage
  logic rst_n_r; // released reset for the design

  always_ff @(posedge sys_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      rst_meta_r <= 1'b0;
      rst_n_r <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_n_r <= rst_meta_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // external pin edges
  tlvirq_edge_if eif ();

  assign eif.pin = {ext_request_2_i, ext_request_1_i, ext_request_0_i};
  assign eif.mode[0] = tlvirq_pkg::tlvirq_edge_t'(ext_mode_i[1:0]);
  assign eif.mode[1] = tlvirq_pkg::tlvirq_edge_t'(ext_mode_i[3:2]);
  assign eif.mode[2] = tlvirq_pkg::tlvirq_edge_t'(ext_mode_i[5:4]);

  tlvirq_edge u_edge (
    .clk_i(sys_clk_i),
    .rst_n_i(rst_n_r),
    .eif(eif)
  );

  ////////////////////////////////////////////////////////////////////////////
  // vector of a source
  function automatic logic [15:0] vec_of(input tlvirq_pkg::tlvirq_src_t idx);
    if (idx == `TLVIRQ_SRC_CMP)
    begin
      vec_of = `TLVIRQ_VEC_CMP;
    end
    else
    begin
      vec_of = 16'(`TLVIRQ_VEC_BASE + `TLVIRQ_VEC_STEP * {12'h000, idx});
    end
  endfunction : vec_of

  ////////////////////////////////////////////////////////////////////////////
  // flags and their set/clear terms
  logic [`TLVIRQ_NFLAG-1:0] flag_r; // pending flags, bit 12 is tx done
  logic [`TLVIRQ_NFLAG-1:0] set_ev; // hardware set events
  logic [`TLVIRQ_NFLAG-1:0] clr_ev; // clear terms
  logic [NSRC-1:0] pend; // pending per source
  logic [NSRC-1:0] acc_onehot; // accepted source
  logic accept; // core takes the request
  tlvirq_pkg::tlvirq_src_t sel_r; // source behind the presented vector

  assign accept = irq_accept_i & irq_req_o;

  // one-hot of the accepted source
  always_comb
  begin
    acc_onehot = '0;
    if (accept)
    begin
      acc_onehot[sel_r] = 1'b1;
    end
  end

  // hardware set events in flag order
  always_comb
  begin
    set_ev = '0;
    set_ev[`TLVIRQ_SRC_EXT0] = eif.hit[0];
    set_ev[`TLVIRQ_SRC_T0] = timer0_overflow_i;
    set_ev[`TLVIRQ_SRC_EXT1] = eif.hit[1];
    set_ev[`TLVIRQ_SRC_T1] = timer1_overflow_i;
    set_ev[`TLVIRQ_SRC_UART] = serial_rx_done_i;
    set_ev[`TLVIRQ_SRC_T2] = timer2_overflow_i;
    set_ev[`TLVIRQ_SRC_ADC] = conversion_end_i;
    set_ev[`TLVIRQ_SRC_SSI] = sync_serial_done_i;
    set_ev[`TLVIRQ_SRC_PWM] = pwm_period_pass_i;
    set_ev[`TLVIRQ_SRC_BTM] = base_timer_tick_i;
    set_ev[`TLVIRQ_SRC_EXT2] = eif.hit[2];
    set_ev[`TLVIRQ_SRC_CMP] = comparator_event_i;
    set_ev[`TLVIRQ_FLAG_TX] = serial_tx_done_i;
  end

  // clear terms: software, acceptance of auto sources, conversion start
  always_comb
  begin
    clr_ev = flag_clear_i;
    clr_ev[NSRC-1:0] = clr_ev[NSRC-1:0] | (acc_onehot & `TLVIRQ_HW_AUTO);
    clr_ev[`TLVIRQ_SRC_ADC] = clr_ev[`TLVIRQ_SRC_ADC] | conversion_start_i;
  end

  // flag storage, set wins over clear
  always_ff @(posedge sys_clk_i or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      flag_r <= `TLVIRQ_FLAG_RST;
    end
    else
    begin
      for (int i = 0; i < `TLVIRQ_NFLAG; i++)
      begin
        if (set_ev[i])
        begin
          flag_r[i] <= 1'b1;
        end
        else if (clr_ev[i])
        begin
          flag_r[i] <= 1'b0;
        end
      end
    end
  end

  // pending view, serial shares one source
  always_comb
  begin
    pend = flag_r[NSRC-1:0];
    pend[`TLVIRQ_SRC_UART] = flag_r[`TLVIRQ_SRC_UART] | flag_r[`TLVIRQ_FLAG_TX];
  end

  assign flags_o = flag_r;

  ////////////////////////////////////////////////////////////////////////////
  // arbitration
  logic [NSRC-1:0] live; // enabled pending sources
  logic hi_any; // some high-level candidate
  logic lo_any; // some low-level candidate
  tlvirq_pkg::tlvirq_src_t hi_idx; // first high candidate
  tlvirq_pkg::tlvirq_src_t lo_idx; // first low candidate
  logic hi_act_r; // high routine running
  logic lo_act_r; // low routine running
  logic cand_ok; // candidate may be presented
  tlvirq_pkg::tlvirq_src_t cand_idx; // candidate source

  assign live = pend & irq_enable_i & {NSRC{global_irq_enable_i}};

  // lowest index per level, scanned downward so lowest wins
  always_comb
  begin
    hi_any = 1'b0;
    lo_any = 1'b0;
    hi_idx = '0;
    lo_idx = '0;
    for (int i = NSRC - 1; i >= 0; i--)
    begin
      if (live[i] && irq_prio_high_i[i])
      begin
        hi_any = 1'b1;
        hi_idx = tlvirq_pkg::tlvirq_src_t'(i);
      end
      if (live[i] && !irq_prio_high_i[i])
      begin
        lo_any = 1'b1;
        lo_idx = tlvirq_pkg::tlvirq_src_t'(i);
      end
    end
  end

  // level first, equal level never preempts
  always_comb
  begin
    if (hi_any && !hi_act_r)
    begin
      cand_ok = 1'b1;
      cand_idx = hi_idx;
    end
    else if (lo_any && !hi_act_r && !lo_act_r)
    begin
      cand_ok = 1'b1;
      cand_idx = lo_idx;
    end
    else
    begin
      cand_ok = 1'b0;
      cand_idx = hi_any ? hi_idx : lo_idx;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // request and vector presented to the core
  logic req_r; // request to core
  logic [15:0] vec_r; // vector to core

  always_ff @(posedge sys_clk_i or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      req_r <= 1'b0;
      vec_r <= `TLVIRQ_VEC_RST;
      sel_r <= '0;
    end
    else
    begin
      req_r <= cand_ok & ~accept;
      vec_r <= vec_of(cand_idx);
      sel_r <= cand_idx;
    end
  end

  assign irq_req_o = req_r;
  assign irq_vector_o = vec_r;

  ////////////////////////////////////////////////////////////////////////////
  // in-service levels, return ends the innermost
  always_ff @(posedge sys_clk_i or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      hi_act_r <= 1'b0;
      lo_act_r <= 1'b0;
    end
    else if (accept)
    begin
      if (irq_prio_high_i[sel_r])
      begin
        hi_act_r <= 1'b1;
      end
      else
      begin
        lo_act_r <= 1'b1;
      end
    end
    else if (irq_return_i)
    begin
      if (hi_act_r)
      begin
        hi_act_r <= 1'b0;
      end
      else
      begin
        lo_act_r <= 1'b0;
      end
    end
  end

  assign in_service_o = {hi_act_r, lo_act_r};

  ////////////////////////////////////////////////////////////////////////////
  // stop wake-up from capable, enabled sources only
  logic wake_r; // registered wake

  always_ff @(posedge sys_clk_i or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      wake_r <= 1'b0;
    end
    else
    begin
      wake_r <= stop_mode_i & |(pend & irq_enable_i & `TLVIRQ_WAKE_MASK);
    end
  end

  assign wake_o = wake_r;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_r);

  global_gate_a: assert property (!global_irq_enable_i |=> !irq_req_o)
    else $error("request without global enable");
  // vector rebuilt from the layout directly, not through the shared function
  vector_map_a: assert property (irq_req_o |-> irq_vector_o ==
    ((sel_r == `TLVIRQ_SRC_CMP) ? `TLVIRQ_VEC_CMP : {9'h000, sel_r, 3'h3}))
    else $error("vector does not match source");
  timer_autoclr_a: assert property (accept && sel_r == `TLVIRQ_SRC_T0
    && !timer0_overflow_i |=> !flag_r[`TLVIRQ_SRC_T0])
    else $error("timer 0 flag not cleared on accept");
  timer2_hold_a: assert property (flag_r[`TLVIRQ_SRC_T2]
    && !flag_clear_i[`TLVIRQ_SRC_T2] |=> flag_r[`TLVIRQ_SRC_T2])
    else $error("timer 2 flag lost");
  serial_hold_a: assert property (flag_r[`TLVIRQ_FLAG_TX]
    && !flag_clear_i[`TLVIRQ_FLAG_TX] |=> flag_r[`TLVIRQ_FLAG_TX])
    else $error("serial tx flag lost");
  conv_start_a: assert property (conversion_start_i && !conversion_end_i
    |=> !flag_r[`TLVIRQ_SRC_ADC])
    else $error("conversion start did not clear flag");
  pwm_set_a: assert property (pwm_period_pass_i |=> flag_r[`TLVIRQ_SRC_PWM])
    else $error("pwm flag not set");
  no_preempt_a: assert property (hi_act_r |-> !irq_req_o)
    else $error("request while high routine runs");
  wake_stop_a: assert property (wake_o |-> $past(stop_mode_i))
    else $error("wake outside stop");
  held_pending_a: assert property (lo_act_r && !hi_act_r && lo_any && !hi_any
    && !irq_return_i ##1 irq_return_i |-> ##[1:2] irq_req_o)
    else $error("held request not taken after return");

  accept_c: cover property (accept);
  nested_c: cover property (hi_act_r && lo_act_r);
  wake_c: cover property (wake_o);
endmodule : tlvirq_top
`default_nettype wire

// *** tlvirq_core_model.sv ***
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////
// core stand-in: takes presented requests after a set wait, tracks
// nesting depth, and returns from a routine when told to
module tlvirq_core_model (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic req_i,
  input wire logic [15:0] vec_i,
  input wire logic take_en_i,
  input wire logic [3:0] lat_i,
  input wire logic ret_go_i,
  output logic accept_o,
  output logic return_o,
  output logic [15:0] pc_o
);
  logic [3:0] wait_r; // cycles the request has stood
  logic [1:0] depth_r; // routines currently entered
  ////////////////////////////////////////////////////////////////////////
  // accept and return are never in the same cycle; a return wins
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      accept_o <= 1'b0;
      return_o <= 1'b0;
      pc_o <= 16'h0000;
      depth_r <= 2'b00;
    end
    else
    begin
      accept_o <= 1'b0;
      return_o <= 1'b0;
      // return lowers the nesting depth
      if (ret_go_i && depth_r != 2'b00 && !accept_o)
      begin
        return_o <= 1'b1;
        depth_r <= depth_r - 2'b01;
      end
      // accept loads the vector into the counter and raises the depth
      else if (take_en_i && req_i && !accept_o && wait_r >= lat_i)
      begin
        accept_o <= 1'b1;
        pc_o <= vec_i;
        depth_r <= depth_r + 2'b01;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // wait counter, restarts after every accept or dropped request
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      wait_r <= 4'h0;
    end
    else if (!req_i || accept_o)
    begin
      wait_r <= 4'h0;
    end
    else if (wait_r != 4'hf)
    begin
      wait_r <= wait_r + 4'h1;
    end
  end
endmodule : tlvirq_core_model
`default_nettype wire

// *** two_level_vectored_irq_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////
// self-checking bench for the vectored interrupt controller
module two_level_vectored_irq_tb;
  logic clk = 0, rst_n = 0, glob = 0, stop = 0, take_en = 0, ret_go = 0, conv_go = 0;
  logic [11:0] en = 0, prio = 0, m = 0; // enables, levels, random mask
  logic [2:0] pins = 0; // external pin levels
  logic [5:0] mode = 6'h3f; // both edges on every pin
  logic [12:0] ev = 0, clr = 0; // event pulses, software clears
  logic [3:0] lat = 0; // core accept wait
  wire logic req, wake, acc, ret;
  wire logic [15:0] vec;
  wire logic [12:0] flags;
  wire logic [1:0] insvc;
  int fail_count = 0, n_tests = 0, seed = 91077;
  ////////////////////////////////////////////////////////////////////////
  // design and core stand-in
  tlvirq_top #(.NSRC(12)) i_dut (.sys_clk_i(clk), .resetn_i(rst_n),
    .global_irq_enable_i(glob), .irq_enable_i(en), .irq_prio_high_i(prio),
    .ext_request_0_i(pins[0]), .ext_request_1_i(pins[1]), .ext_request_2_i(pins[2]),
    .ext_mode_i(mode), .timer0_overflow_i(ev[1]), .timer1_overflow_i(ev[3]),
    .timer2_overflow_i(ev[5]), .serial_rx_done_i(ev[4]), .serial_tx_done_i(ev[12]),
    .conversion_start_i(conv_go), .conversion_end_i(ev[6]), .sync_serial_done_i(ev[7]),
    .pwm_period_pass_i(ev[8]), .base_timer_tick_i(ev[9]), .comparator_event_i(ev[11]),
    .flag_clear_i(clr), .stop_mode_i(stop), .irq_accept_i(acc), .irq_return_i(ret),
    .irq_req_o(req), .irq_vector_o(vec), .flags_o(flags), .in_service_o(insvc),
    .wake_o(wake));
  tlvirq_core_model i_core (.clk_i(clk), .rst_n_i(rst_n), .req_i(req), .vec_i(vec),
    .take_en_i(take_en), .lat_i(lat), .ret_go_i(ret_go), .accept_o(acc),
    .return_o(ret), .pc_o());
  ////////////////////////////////////////////////////////////////////////
  // 25 MHz clock
  initial forever #20 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////
  // expectations
  function automatic logic [15:0] vec_of(int i);
    return (i == 11) ? 16'h0063 : 16'h0003 + (16'(i) << 3);
  endfunction : vec_of
  function automatic logic auto_clr(int i);
    return i inside {0, 1, 2, 3, 10};
  endfunction : auto_clr
  function automatic logic wake_cap(int i);
    return i inside {0, 2, 9, 10, 11};
  endfunction : wake_cap
  // winner: high level first, then lowest index
  function automatic int pick(logic [11:0] mk, logic [11:0] pr);
    int w;
    w = 0;
    for (int i = 11; i >= 0; i--) if (mk[i]) w = i;
    for (int i = 11; i >= 0; i--) if (mk[i] && pr[i]) w = i;
    return w;
  endfunction : pick
  ////////////////////////////////////////////////////////////////////////
  // helpers: inputs always move 1 ns after the edge
  task tick(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  // wide enough for every packed group of outputs compared below
  task chk(string nm, logic [31:0] seen, logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task results();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : results
  // one event per mask bit; pins toggle for external sources
  task fire(logic [12:0] mk);
    pins = pins ^ {mk[10], mk[2], mk[0]};
    ev = mk;
    tick(1);
    ev = 0;
    tick(4);
  endtask : fire
  task clear_all();
    clr = 13'h1fff;
    tick(1);
    clr = 0;
    tick(2);
  endtask : clear_all
  task ret_once();
    ret_go = 1;
    tick(1);
    ret_go = 0;
    tick(3);
  endtask : ret_once
  // bounded wait for the in-service state
  task wait_svc(logic [1:0] want);
    int k;
    k = 0;
    while (insvc !== want && k < 40)
    begin
      tick(1);
      k++;
    end
    chk("in_service", insvc, want);
    if (k == 40) results();
  endtask : wait_svc
  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    tick(8);
    rst_n = 1;
    tick(2);
    chk("reset outputs", {req, insvc, wake, flags}, 16'h0000);
    chk("reset vector", vec, 16'h0000);
    tick(2);
    // every source alone: wake, gating, vector, clearing
    for (int i = 0; i < 12; i++)
    begin
      en = 12'(1) << i;
      glob = 0;
      stop = 1;
      lat = 4'(i);
      fire(13'(1) << i);
      chk("wake", wake, wake_cap(i));
      chk("req gated", req, 0);
      chk("flag set", flags[i], 1);
      stop = 0;
      glob = 1;
      tick(2);
      chk("req", req, 1);
      chk("vector", vec, vec_of(i));
      take_en = 1;
      wait_svc(2'b01);
      take_en = 0;
      tick(1);
      chk("flag after accept", flags[i], !auto_clr(i));
      chk("req in service", req, 0);
      clr = 13'(1) << i;
      tick(1);
      clr = 0;
      ret_once();
      chk("in_service", insvc, 2'b00);
    end
    // random pending sets and levels
    en = 12'hfff;
    repeat (20)
    begin
      m = 12'($random(seed)) & 12'hbfa;
      if (m == 0) m = 12'h002;
      prio = 12'($random(seed));
      fire({1'b0, m});
      chk("arbitration", vec, vec_of(pick(m, prio)));
      clear_all();
    end
    // nesting: low routine, held low, preempting high
    prio = 12'h008;
    lat = 4'h2;
    fire(13'h0002);
    take_en = 1;
    wait_svc(2'b01);
    take_en = 0;
    fire(13'h0020);
    chk("low held", req, 0);
    fire(13'h0008);
    chk("preempt", {req, vec[14:0]}, 16'h801b);
    take_en = 1;
    wait_svc(2'b11);
    take_en = 0;
    ret_once();
    chk("high ended", {req, insvc}, 16'h0001);
    ret_once();
    tick(1);
    chk("pending served", {req, insvc, vec[12:0]}, 16'h802b);
    clear_all();
    // flags that set with the source disabled, conversion start, serial tx
    en = 0;
    fire(13'h0140);
    chk("flags no enable", {req, flags[8], flags[6]}, 16'h0003);
    conv_go = 1;
    tick(1);
    conv_go = 0;
    tick(1);
    chk("conversion start", flags[6], 0);
    // overflow and software clear in one cycle: the set wins
    ev = 13'h0020;
    clr = 13'h0020;
    tick(1);
    ev = 0;
    clr = 0;
    tick(1);
    chk("set wins", flags[5], 1);
    clear_all();
    en = 12'h010;
    fire(13'h1000);
    chk("serial tx", {req, flags[12], vec[13:0]}, 16'hc023);
    clear_all();
    // trigger modes on all three pins
    en = 0;
    pins = 0;
    tick(3);
    clear_all();
    for (int k = 0; k < 4; k++)
    begin
      mode = {3{2'(k)}};
      tick(2);
      pins = 3'b111;
      tick(4);
      chk("rising", {flags[10], flags[2], flags[0]}, {3{k[0]}});
      clear_all();
      pins = 0;
      tick(4);
      chk("falling", {flags[10], flags[2], flags[0]}, {3{k[1]}});
      clear_all();
    end
    results();
  end
endmodule : two_level_vectored_irq_tb
`default_nettype wire
